// *** pkg/acfb_pkg.sv ***
/*
  Package for the autoclass, foldback and program memory load register block.
  Holds command codes, field positions, reset values, timing counts and the
  carrier structs shared by the register block, its checker, the memory model and the bench.
  Assumes a 20 MHz system clock and an I2C command layer outside this block.
*/
package acfb_pkg;

  // ------------------------------------------------------------
  // Command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_VERSION   = 8'h41;
  localparam logic [7:0] CMD_AC_POWER1 = 8'h51;
  localparam logic [7:0] CMD_AC_POWER2 = 8'h52;
  localparam logic [7:0] CMD_AC_POWER3 = 8'h53;
  localparam logic [7:0] CMD_AC_POWER4 = 8'h54;
  localparam logic [7:0] CMD_ALT_CURVE = 8'h55;
  localparam logic [7:0] CMD_MEM_CTRL  = 8'h60;
  localparam logic [7:0] CMD_MEM_DATA  = 8'h61;
  localparam logic [7:0] CMD_START_LO  = 8'h62;
  localparam logic [7:0] CMD_START_HI  = 8'h63;

  // ------------------------------------------------------------
  // Control register field positions
  // ------------------------------------------------------------
  localparam int CTL_ACCESS_SEL = 7;
  localparam int CTL_CPU_HOLD   = 6;
  localparam int CTL_RESERVED   = 5;
  localparam int CTL_CHECK_EN   = 4;
  localparam int CTL_RUN_MEM    = 3;
  localparam int CTL_CHECK_SEL  = 2;
  localparam int CTL_DIR_READ   = 1;
  localparam int CTL_PTR_CLEAR  = 0;

  // ------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [6:0]  RST_COUNT    = 7'h00;
  localparam logic [15:0] RST_ADDR     = 16'h0000;
  localparam logic [7:0]  VERSION_BAD  = 8'hFF;
  localparam logic [7:0]  VERSION_NONE = 8'h00;
  localparam int          COUNT_W      = 7;
  // Power step in milliwatts per count
  localparam int          POWER_STEP_MW = 500;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ         = 20_000_000;
  localparam int CHECK_LIMIT_US = 1000;
  localparam int CHECK_CYCLES   = (CHECK_LIMIT_US * (CLK_HZ / 1_000_000));

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic       stop;
  } host_req_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        check_bits;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_t;

endpackage : acfb_pkg

// *** logic/acfb_load_ptr.sv ***
/*
  Load address pointer for the program memory data port.
  Assumes clear and step come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module acfb_load_ptr #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              sys_rst_i,
  // Control
  input  wire logic              clear_i,
  input  wire logic [ADDR_W-1:0] start_i,
  input  wire logic              step_i,
  // Pointer
  output logic      [ADDR_W-1:0] addr_o
);

  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;

  // Clear loads start address; each byte advances one
  assign addr_d = clear_i ? start_i
                : step_i  ? ADDR_W'(addr_q + ADDR_W'(1)) : addr_q;
  assign addr_o = addr_q;

  // Pointer register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      addr_q <= '0;
    end else begin
      addr_q <= addr_d;
    end
  end

endmodule : acfb_load_ptr
`default_nettype wire

// *** logic/acfb_code_check.sv ***
/*
  Code check timer: after a run request, waits for the verdict of the
  code checker and forces failure if none arrives inside the limit.
  Assumes the verdict inputs come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module acfb_code_check #(
  parameter int LIMIT = acfb_pkg::CHECK_CYCLES
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  // Start and verdict
  input  wire logic       start_i,
  input  wire logic       done_i,
  input  wire logic [7:0] version_i,
  // Result
  output logic            busy_o,
  output logic            result_o,
  output logic [7:0]      version_o
);

  logic        busy_q;
  logic        result_q;
  logic [7:0]  version_q;
  logic [31:0] cnt_q;
  logic        timeout;
  logic        finish;
  logic        bad;

  // A timeout, code FFh or code 00h means a bad image
  assign timeout = busy_q && (cnt_q == 32'(LIMIT - 1));
  assign finish  = busy_q && (done_i || timeout);
  assign bad     = timeout || (version_i == acfb_pkg::VERSION_BAD)
                || (version_i == acfb_pkg::VERSION_NONE);
  assign busy_o    = busy_q;
  assign result_o  = result_q;
  assign version_o = version_q;

  // Check sequencing, bounded to the limit
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      busy_q    <= 1'b0;
      result_q  <= 1'b0;
      version_q <= 8'h00;
      cnt_q     <= '0;
    end else begin
      result_q <= finish;
      if (start_i) begin
        busy_q <= 1'b1;
        cnt_q  <= '0;
      end else if (finish) begin
        busy_q    <= 1'b0;
        version_q <= bad ? acfb_pkg::VERSION_BAD : version_i;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 32'd1;
      end
    end
  end

endmodule : acfb_code_check
`default_nettype wire

// *** logic/acfb_regs.sv ***
/*
  Command-addressed register block: autoclass power readback, alternate
  foldback curve enables, program memory load control with data port and
  start address, and the post-load code check status.
  Assumes an I2C slave front end that delivers one decoded byte request per
  cycle on the same clock, marks STOP, and only passes the lower address.
  Assumes program memory answers a read combinationally to the address on
  the registered memory request. That address trails a pointer step by one
  cycle, so data-port reads need one idle cycle between them.
  I2C delivers bytes far slower than that, so the spacing costs nothing
  and saves a read-ahead buffer.
  Assumes the measurement and verdict inputs come from logic on this clock,
  so they pass no synchroniser.
*/
`timescale 1ns/10ps
`default_nettype none

module acfb_regs #(
  parameter int CHANNELS     = 4,
  parameter int ADDR_W       = 16,
  parameter int CHECK_LIMIT  = acfb_pkg::CHECK_CYCLES
) (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  sys_rst_i,
  // Host register requests
  input  wire acfb_pkg::host_req_t   host_req_i,
  output logic [7:0]                 host_rdata_o,
  output logic                       host_rvalid_o,
  // Autoclass measurement results
  input  wire logic [CHANNELS-1:0]   meas_valid_i,
  input  wire logic [CHANNELS*7-1:0] meas_count_i,
  // Program memory port
  output acfb_pkg::mem_req_t         mem_req_o,
  input  wire logic [7:0]            mem_rdata_i,
  // Code check verdict
  input  wire logic                  check_done_i,
  input  wire logic [7:0]            check_version_i,
  // Block controls
  output logic [CHANNELS-1:0]        alt_operating_curve_en_o,
  output logic [CHANNELS-1:0]        alt_inrush_curve_en_o,
  output logic                       cpu_hold_o,
  output logic                       check_bits_verify_enable_o,
  output logic                       run_from_memory_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LOAD_IDLE   = 2'b00,
    LOAD_STREAM = 2'b01,
    LOAD_CHECK  = 2'b10
  } load_state_t;

  // Load sequence
  load_state_t         state_q;
  load_state_t         state_d;

  // Host-visible registers
  logic [6:0]          count_q [CHANNELS];
  logic [7:0]          alt_q;
  logic [7:0]          ctl_q;
  logic [7:0]          ctl_d;
  logic [7:0]          start_lo_q;
  logic [7:0]          start_hi_q;

  // Answer and memory request stage
  logic [7:0]          rdata_q;
  logic [7:0]          rdata_d;
  logic                rvalid_q;
  acfb_pkg::mem_req_t  mem_q;
  acfb_pkg::mem_req_t  mem_d;
  logic                run_q;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  function automatic logic hit(input acfb_pkg::host_req_t r, input logic [7:0] c);
    hit = (r.cmd == c);
  endfunction : hit

  // Count read back; the unused top bit always reads low
  function automatic logic [7:0] count_byte(input logic [6:0] c);
    count_byte = {1'b0, c};
  endfunction : count_byte

  // Write strobes
  logic        wr_ctl;
  logic        wr_alt;
  logic        wr_lo;
  logic        wr_hi;

  // Data port qualifiers
  logic        data_wr;
  logic        data_rd;
  logic        access_en;
  logic        dir_read;
  logic        ptr_clear;
  logic [15:0] start_addr;
  logic [ADDR_W-1:0] ptr;

  // Code check handshake
  logic        run_rise;
  logic        chk_busy;
  logic        chk_result;
  logic [7:0]  version;

  assign wr_ctl     = host_req_i.wr && hit(host_req_i, acfb_pkg::CMD_MEM_CTRL);
  assign wr_alt     = host_req_i.wr && hit(host_req_i, acfb_pkg::CMD_ALT_CURVE);
  assign wr_lo      = host_req_i.wr && hit(host_req_i, acfb_pkg::CMD_START_LO);
  assign wr_hi      = host_req_i.wr && hit(host_req_i, acfb_pkg::CMD_START_HI);
  assign access_en  = ctl_q[acfb_pkg::CTL_ACCESS_SEL];
  assign dir_read   = ctl_q[acfb_pkg::CTL_DIR_READ];
  assign ptr_clear  = ctl_q[acfb_pkg::CTL_PTR_CLEAR];

  // ------------------------------------------------------------
  // Data port
  // ------------------------------------------------------------
  // Data port moves only when enabled, released and in the matching direction
  assign data_wr    = host_req_i.wr && hit(host_req_i, acfb_pkg::CMD_MEM_DATA)
                   && access_en && !ptr_clear && !dir_read;
  assign data_rd    = host_req_i.rd && hit(host_req_i, acfb_pkg::CMD_MEM_DATA)
                   && access_en && !ptr_clear && dir_read;
  assign start_addr = {start_hi_q, start_lo_q};
  // The code check starts on the rising run bit with access closed
  assign run_rise   = wr_ctl && host_req_i.wdata[acfb_pkg::CTL_RUN_MEM]
                   && !ctl_q[acfb_pkg::CTL_RUN_MEM]
                   && !host_req_i.wdata[acfb_pkg::CTL_ACCESS_SEL];

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Pointer follows the start address while clear is high, so address
  // writes made during the clear take effect without a second toggle
  acfb_load_ptr #(
    .ADDR_W (ADDR_W)
  ) u_ptr (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .clear_i   (ptr_clear),
    .start_i   (ADDR_W'(start_addr)),
    .step_i    (data_wr || data_rd),
    .addr_o    (ptr)
  );

  // Timer bounds the verdict wait; a silent checker ends as a bad image,
  // so a run bit raised with access closed can never stay set unchecked
  acfb_code_check #(
    .LIMIT (CHECK_LIMIT)
  ) u_check (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (run_rise),
    .done_i    (check_done_i),
    .version_i (check_version_i),
    .busy_o    (chk_busy),
    .result_o  (chk_result),
    .version_o (version)
  );

  // ------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------
  // Control write, and clearing of the run bit on a bad image
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d = host_req_i.wdata;
    end
    // Applied last so the bad-image clear beats a host write in the same cycle
    if (chk_result && (version == acfb_pkg::VERSION_BAD)) begin
      ctl_d[acfb_pkg::CTL_RUN_MEM] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Memory request
  // ------------------------------------------------------------
  // Memory request: one byte per data-port access
  always_comb begin
    mem_d            = '0;
    mem_d.wr         = data_wr;
    mem_d.rd         = data_rd;
    mem_d.check_bits = ctl_q[acfb_pkg::CTL_CHECK_SEL];
    mem_d.addr       = 16'(ptr);
    mem_d.wdata      = host_req_i.wdata;
  end

  // ------------------------------------------------------------
  // Read back
  // ------------------------------------------------------------
  // Read multiplexer; reserved bit seven of counts reads zero
  always_comb begin
    rdata_d = acfb_pkg::RST_BYTE;
    case (host_req_i.cmd)
      acfb_pkg::CMD_AC_POWER1: rdata_d = count_byte(count_q[0]);
      acfb_pkg::CMD_AC_POWER2: rdata_d = count_byte(count_q[1]);
      acfb_pkg::CMD_AC_POWER3: rdata_d = count_byte(count_q[2]);
      acfb_pkg::CMD_AC_POWER4: rdata_d = count_byte(count_q[3]);
      acfb_pkg::CMD_ALT_CURVE: rdata_d = alt_q;
      acfb_pkg::CMD_MEM_CTRL:  rdata_d = ctl_q;
      acfb_pkg::CMD_MEM_DATA:  rdata_d = data_rd ? mem_rdata_i : acfb_pkg::RST_BYTE;
      acfb_pkg::CMD_START_LO:  rdata_d = start_lo_q;
      acfb_pkg::CMD_START_HI:  rdata_d = start_hi_q;
      acfb_pkg::CMD_VERSION:   rdata_d = version;
      default:                 rdata_d = acfb_pkg::RST_BYTE;
    endcase
  end

  // ------------------------------------------------------------
  // Load sequence
  // ------------------------------------------------------------
  // Load sequence tracking; a STOP ends a streaming transfer
  always_comb begin
    state_d = state_q;
    case (state_q)
      LOAD_IDLE: begin
        if (data_wr || data_rd) begin
          state_d = LOAD_STREAM;
        end else if (run_rise) begin
          state_d = LOAD_CHECK;
        end
      end
      LOAD_STREAM: begin
        if (host_req_i.stop) begin
          state_d = LOAD_IDLE;
        end
      end
      LOAD_CHECK: begin
        if (!chk_busy && !run_rise) begin
          state_d = LOAD_IDLE;
        end
      end
      default: state_d = LOAD_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Measured counts, each step half a watt, from peak average power
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        count_q[i] <= acfb_pkg::RST_COUNT;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (meas_valid_i[i]) begin
          count_q[i] <= meas_count_i[i*7 +: 7];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Host-writable registers
  // ------------------------------------------------------------
  // Host-writable registers; processor hold never clears them
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      alt_q      <= acfb_pkg::RST_BYTE;
      ctl_q      <= acfb_pkg::RST_BYTE;
      start_lo_q <= acfb_pkg::RST_BYTE;
      start_hi_q <= acfb_pkg::RST_BYTE;
    end else begin
      ctl_q <= ctl_d;
      if (wr_alt) begin
        alt_q <= host_req_i.wdata;
      end
      if (wr_lo) begin
        start_lo_q <= host_req_i.wdata;
      end
      if (wr_hi) begin
        start_hi_q <= host_req_i.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Answer stage
  // ------------------------------------------------------------
  // Host answers and memory strobes, one cycle after the request
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_q  <= acfb_pkg::RST_BYTE;
      rvalid_q <= 1'b0;
      mem_q    <= '0;
      run_q    <= 1'b0;
      state_q  <= LOAD_IDLE;
    end else begin
      rdata_q  <= host_req_i.rd ? rdata_d : rdata_q;
      rvalid_q <= host_req_i.rd;
      mem_q    <= mem_d;
      run_q    <= ctl_d[acfb_pkg::CTL_RUN_MEM];
      state_q  <= state_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Operating curve bits are upper nibble, inrush lower nibble
  assign alt_operating_curve_en_o   = alt_q[7:4];
  assign alt_inrush_curve_en_o      = alt_q[3:0];

  // Control bits leave as levels; processor hold touches no register here
  assign cpu_hold_o                 = ctl_q[acfb_pkg::CTL_CPU_HOLD];
  assign check_bits_verify_enable_o = ctl_q[acfb_pkg::CTL_CHECK_EN];
  assign run_from_memory_o          = run_q;

  // Host answer and memory request come straight from their stage flops
  assign host_rdata_o               = rdata_q;
  assign host_rvalid_o              = rvalid_q;
  assign mem_req_o                  = mem_q;

endmodule : acfb_regs
`default_nettype wire

// *** sim/acfb_regs_properties.sv ***
/*
  Port-level properties of the register block.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module acfb_regs_checker #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input wire logic                clock_i,
  input wire logic                sys_rst_i,
  // Watched ports
  input wire acfb_pkg::host_req_t host_req_i,
  input wire logic [7:0]          host_rdata_o,
  input wire logic                host_rvalid_o,
  input wire acfb_pkg::mem_req_t  mem_req_o,
  input wire logic [CHANNELS-1:0] alt_operating_curve_en_o,
  input wire logic [CHANNELS-1:0] alt_inrush_curve_en_o,
  input wire logic                cpu_hold_o,
  input wire logic                check_bits_verify_enable_o,
  input wire logic                run_from_memory_o
);
  // Request decodes
  wire rd_cnt = host_req_i.rd && host_req_i.cmd inside {[8'h51:8'h54]};
  wire wr_alt = host_req_i.wr && host_req_i.cmd == acfb_pkg::CMD_ALT_CURVE;
  wire wr_ctl = host_req_i.wr && host_req_i.cmd == acfb_pkg::CMD_MEM_CTRL;
  wire is_dat = host_req_i.cmd == acfb_pkg::CMD_MEM_DATA;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  property p_rvalid; host_req_i.rd |=> host_rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_stray; !host_req_i.rd |=> !host_rvalid_o; endproperty
  a_stray: assert property (p_stray) else $error("stray read valid");
  property p_msb; rd_cnt |=> !host_rdata_o[7]; endproperty
  a_msb: assert property (p_msb) else $error("count top bit set");
  property p_alt_op; wr_alt |=> alt_operating_curve_en_o == $past(host_req_i.wdata[7:4]); endproperty
  a_alt_op: assert property (p_alt_op) else $error("operating curve enables wrong");
  property p_alt_ir; wr_alt |=> alt_inrush_curve_en_o == $past(host_req_i.wdata[3:0]); endproperty
  a_alt_ir: assert property (p_alt_ir) else $error("inrush curve enables wrong");
  property p_hold; wr_ctl |=> cpu_hold_o == $past(host_req_i.wdata[6]); endproperty
  a_hold: assert property (p_hold) else $error("processor hold wrong");
  property p_par; wr_ctl |=> check_bits_verify_enable_o == $past(host_req_i.wdata[4]); endproperty
  a_par: assert property (p_par) else $error("check enable wrong");
  property p_run; wr_ctl |=> ##1 run_from_memory_o == $past(host_req_i.wdata[3], 2); endproperty
  a_run: assert property (p_run) else $error("run from memory wrong");
  property p_mwr; mem_req_o.wr |-> $past(host_req_i.wr && is_dat) && mem_req_o.wdata == $past(host_req_i.wdata);
  endproperty
  a_mwr: assert property (p_mwr) else $error("memory write without data port write");
  property p_mrd; mem_req_o.rd |-> $past(host_req_i.rd && is_dat); endproperty
  a_mrd: assert property (p_mrd) else $error("memory read without data port read");
  property p_step; mem_req_o.wr ##1 mem_req_o.wr |-> mem_req_o.addr == $past(mem_req_o.addr) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("pointer did not step by one");
endmodule : acfb_regs_checker

bind acfb_regs acfb_regs_checker #(.CHANNELS(CHANNELS)) i_acfb_regs_checker (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .host_req_i(host_req_i), .host_rdata_o(host_rdata_o),
  .host_rvalid_o(host_rvalid_o), .mem_req_o(mem_req_o), .alt_operating_curve_en_o(alt_operating_curve_en_o),
  .alt_inrush_curve_en_o(alt_inrush_curve_en_o), .cpu_hold_o(cpu_hold_o),
  .check_bits_verify_enable_o(check_bits_verify_enable_o), .run_from_memory_o(run_from_memory_o));
`default_nettype wire

// *** sim/acfb_mem_model.sv ***
/*
  Program memory model: words and check bits, 256 places each.
  Assumes registered one-cycle requests from the register block.
*/
`timescale 1ns/10ps
`default_nettype none
module acfb_mem_model (
  // Clock
  input  wire logic               clock_i,
  // Request and answer
  input  wire acfb_pkg::mem_req_t mem_req_i,
  output logic [7:0]              mem_rdata_o
);
  logic [7:0] words [256];
  logic [7:0] bits  [256];
  wire  [7:0] a = mem_req_i.addr[7:0];

  // Separate stores, one byte per address
  always @(posedge clock_i) begin
    if (mem_req_i.wr && mem_req_i.check_bits) bits[a] <= mem_req_i.wdata;
    if (mem_req_i.wr && !mem_req_i.check_bits) words[a] <= mem_req_i.wdata;
  end
  // Answer follows the address; unwritten places read unknown on purpose
  assign mem_rdata_o = mem_req_i.check_bits ? bits[a] : words[a];
endmodule : acfb_mem_model
`default_nettype wire

// *** sim/testbench.sv ***
/*
  Self-checking bench for the register block with a memory model.
  Assumes the checker is attached by its own bind.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                clock_i = 1'b0;
  logic                sys_rst_i = 1'b1;
  acfb_pkg::host_req_t host_req_i = '0;
  logic [7:0]          host_rdata_o;
  logic                host_rvalid_o;
  logic [3:0]          meas_valid_i = 4'h0;
  logic [27:0]         meas_count_i = 28'h0;
  acfb_pkg::mem_req_t  mem_req_o;
  logic [7:0]          mem_rdata_i;
  logic                check_done_i = 1'b0;
  logic [7:0]          check_version_i = 8'h00;
  logic [3:0]          alt_op, alt_ir;
  logic                hold, check_bits_verify_enable, run;
  int                  n_fail = 0;
  int                  checks_done = 0;
  int                  cycles = 0;
  acfb_pkg::mem_req_t  seen[$];
  logic [7:0]          cmds [9] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h60, 8'h62, 8'h63, 8'h41};

  always #25 clock_i = ~clock_i;

  // Short check limit keeps the timeout case brief
  acfb_regs #(.CHECK_LIMIT(20)) i_acfb_regs (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .host_req_i(host_req_i), .host_rdata_o(host_rdata_o),
    .host_rvalid_o(host_rvalid_o), .meas_valid_i(meas_valid_i), .meas_count_i(meas_count_i),
    .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .check_done_i(check_done_i),
    .check_version_i(check_version_i), .alt_operating_curve_en_o(alt_op), .alt_inrush_curve_en_o(alt_ir),
    .cpu_hold_o(hold), .check_bits_verify_enable_o(check_bits_verify_enable), .run_from_memory_o(run));
  acfb_mem_model i_acfb_mem_model (.clock_i(clock_i), .mem_req_i(mem_req_o), .mem_rdata_o(mem_rdata_i));

  // Memory requests stand one cycle, so sample each edge
  always @(posedge clock_i) if (mem_req_o.wr || mem_req_o.rd) seen.push_back(mem_req_o);

  // ----
  // Driver and compare tasks
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic send(input logic w, input logic r, input logic [7:0] c, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    host_req_i = '{wr: w, rd: r, cmd: c, wdata: d, stop: 1'b0};
  endtask : send
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock_i);
      #1;
      host_req_i = '0;
    end
  endtask : idle
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    send(1'b1, 1'b0, c, d);
    idle(1);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    send(1'b0, 1'b1, c, 8'h00);
    idle(1);
    chk($sformatf("reg %h", c), 32'({1'b1, e}), 32'({host_rvalid_o, host_rdata_o}));
  endtask : rd
  // Reads carry no write data, so that field is masked
  task automatic take(input string what, input logic [25:0] e);
    acfb_pkg::mem_req_t m;
    m = '0;
    if (seen.size() > 0) m = seen.pop_front();
    chk(what, 32'(e), 32'({m.wr, m.check_bits, m.addr, m.rd ? 8'h00 : m.wdata}));
  endtask : take

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    foreach (cmds[i]) rd(cmds[i], 8'h00);
    chk("outputs", 32'h0, 32'({alt_op, alt_ir, hold, check_bits_verify_enable, run}));
  endtask : t_reset
  task automatic t_counts;
    @(posedge clock_i);
    #1;
    meas_count_i = {7'h40, 7'h01, 7'h2A, 7'h7F};
    meas_valid_i = 4'hF;
    idle(1);
    meas_valid_i = 4'h0;
    for (int i = 0; i < 4; i++) rd(8'(8'h51 + i), {1'b0, meas_count_i[7*i+:7]});
    wr(8'h52, 8'hFF);
    rd(8'h52, 8'h2A);
  endtask : t_counts
  // Curves are set ahead of any power-on, which lies outside
  task automatic t_alt;
    logic [7:0] v [2] = '{8'hA5, 8'h5A};
    foreach (v[i]) begin
      wr(8'h55, v[i]);
      rd(8'h55, v[i]);
      chk("curve enables", 32'(v[i]), 32'({alt_op, alt_ir}));
    end
  endtask : t_alt
  task automatic t_ctl;
    wr(8'h60, 8'h74);
    rd(8'h60, 8'h74);
    chk("hold and check", 32'h3, 32'({hold, check_bits_verify_enable}));
    rd(8'h55, 8'h5A);
    wr(8'h60, 8'h00);
    chk("hold released", 32'h0, 32'(hold));
  endtask : t_ctl
  task automatic t_load;
    wr(8'h62, 8'h10);
    wr(8'h63, 8'h01);
    rd(8'h62, 8'h10);
    rd(8'h63, 8'h01);
    wr(8'h60, 8'h81);
    send(1'b1, 1'b0, 8'h61, 8'h77);
    wr(8'h60, 8'h80);
    send(1'b1, 1'b0, 8'h61, 8'hAA);
    send(1'b1, 1'b0, 8'h61, 8'hBB);
    send(1'b1, 1'b0, 8'h61, 8'hCC);
    idle(3);
    take("word 0", {2'b10, 16'h0110, 8'hAA});
    take("word 1", {2'b10, 16'h0111, 8'hBB});
    take("word 2", {2'b10, 16'h0112, 8'hCC});
    chk("stored", 32'h00CC, 32'(i_acfb_mem_model.words[8'h12]));
    wr(8'h60, 8'h85);
    wr(8'h60, 8'h84);
    wr(8'h61, 8'h3C);
    idle(1);
    take("check bits", {2'b11, 16'h0110, 8'h3C});
    wr(8'h60, 8'h83);
    wr(8'h60, 8'h82);
    rd(8'h61, 8'hAA);
    rd(8'h61, 8'hBB);
    idle(3);
    take("read 0", {2'b00, 16'h0110, 8'h00});
    take("read 1", {2'b00, 16'h0111, 8'h00});
    wr(8'h60, 8'h00);
    wr(8'h61, 8'h55);
    rd(8'h61, 8'h00);
    idle(2);
    chk("refused", 32'h0, 32'(seen.size()));
  endtask : t_load
  task automatic t_check;
    wr(8'h60, 8'h18);
    idle(1);
    chk("running", 32'h1, 32'(run));
    check_version_i = 8'h23;
    check_done_i = 1'b1;
    idle(1);
    check_done_i = 1'b0;
    idle(2);
    rd(8'h41, 8'h23);
    chk("still running", 32'h1, 32'(run));
    wr(8'h60, 8'h10);
    wr(8'h60, 8'h18);
    idle(30);
    rd(8'h41, 8'hFF);
    chk("safe mode", 32'h0, 32'(run));
    rd(8'h60, 8'h10);
  endtask : t_check

  // ----
  // Verdict and hang guard
  // ----
  task automatic stop_test;
    $display("Checks made: %0d, mismatches: %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_counts();
    t_alt();
    t_ctl();
    t_load();
    t_check();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
